//--- uap_pkg.sv
// Constants, register map and mode decoding for the port power control
package uap_pkg;

    // Bus geometry
    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    localparam int NUM_SP = 2;

    // Register byte offsets
    localparam logic [4:0] OFS_CFG1 = 5'h00;
    localparam logic [4:0] OFS_CFG7 = 5'h04;
    localparam logic [4:0] OFS_PMODE = 5'h08;
    localparam logic [4:0] OFS_ECR = 5'h0c;
    localparam logic [4:0] OFS_STAT = 5'h10;

    // Reset values
    localparam logic [7:0] CFG1_RST = 8'h9c;
    localparam logic [7:0] CFG7_RST = 8'h00;
    localparam logic [1:0] PMODE_RST = 2'h0;
    localparam logic [7:0] ECR_RST = 8'h00;

    // Field positions
    localparam int CFG1_PP_PWR_BIT = 2;
    localparam int CFG7_PP_AUTO_BIT = 4;
    localparam int CFG7_SP_AUTO_LSB = 5;
    localparam int ECR_MODE_LSB = 5;
    localparam int STAT_EPP_BIT = 4;
    localparam int STAT_ECP_BIT = 5;
    localparam int STAT_PPD_BIT = 6;

    // Configured parallel port modes
    localparam logic [1:0] PMODE_SPP = 2'h0;
    localparam logic [1:0] PMODE_EPP = 2'h1;
    localparam logic [1:0] PMODE_ECP = 2'h2;
    localparam logic [1:0] PMODE_ECP_EPP = 2'h3;

    // Extended control register mode field
    localparam logic [2:0] ECR_SPP = 3'h0;
    localparam logic [2:0] ECR_PS2 = 3'h1;
    localparam logic [2:0] ECR_FIFO = 3'h2;
    localparam logic [2:0] ECR_ECP = 3'h3;
    localparam logic [2:0] ECR_EPP = 3'h4;

    function automatic logic uap_epp_cfg(input logic [1:0] pm);
        uap_epp_cfg = (pm == PMODE_EPP) || (pm == PMODE_ECP_EPP);
    endfunction

    function automatic logic uap_ecp_cfg(input logic [1:0] pm);
        uap_ecp_cfg = (pm == PMODE_ECP) || (pm == PMODE_ECP_EPP);
    endfunction

endpackage

//--- uap_sp_if.sv
// Signals between the top level and one serial power controller
`timescale 1ns/10ps
interface uap_sp_if;
    logic auto_en;
    logic tx_write;
    logic thr_empty;
    logic tsr_empty;
    logic rx_fifo_empty;
    logic rx_idle;
    logic rxd;
    logic ring_line;
    logic tx_pd;
    logic rx_pd;
    logic ring_delta;

    modport ctl (
        input auto_en, tx_write, thr_empty, tsr_empty,
        input rx_fifo_empty, rx_idle, rxd, ring_line,
        output tx_pd, rx_pd, ring_delta
    );
    modport top (
        output auto_en, tx_write, thr_empty, tsr_empty,
        output rx_fifo_empty, rx_idle, rxd, ring_line,
        input tx_pd, rx_pd, ring_delta
    );
endinterface

//--- uap_serial_pm.sv
// Automatic low-power control of one serial transmitter and receiver
`timescale 1ns/10ps
module uap_serial_pm (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic nrst_in,
    // Serial port status and power outputs
    uap_sp_if.ctl sp
);

    typedef enum logic {UAP_TX_ON, UAP_TX_DOWN} uap_tx_st_t;

    uap_tx_st_t tx_st_r;
    uap_tx_st_t tx_st_nxt;
    logic rx_pd_r;
    logic rx_pd_nxt;
    logic rxd_prev_r;
    logic ring_prev_r;
    logic ring_delta_r;
    logic rxd_edge;
    logic ring_edge;

    assign rxd_edge = sp.rxd != rxd_prev_r;
    assign ring_edge = sp.ring_line != ring_prev_r;

    always_comb begin
        tx_st_nxt = tx_st_r;
        case (tx_st_r)
            UAP_TX_ON: begin
                if (sp.auto_en && !sp.tx_write && sp.thr_empty &&
                    sp.tsr_empty) begin
                    tx_st_nxt = UAP_TX_DOWN;
                end
            end
            UAP_TX_DOWN: begin
                // Disable also wakes, so no block is stranded asleep
                if (sp.tx_write || !sp.auto_en) begin
                    tx_st_nxt = UAP_TX_ON;
                end
            end
            default: tx_st_nxt = UAP_TX_ON;
        endcase
    end

    always_comb begin
        rx_pd_nxt = rx_pd_r;
        if (!sp.auto_en || rxd_edge) begin
            rx_pd_nxt = 1'b0;
        end else if (sp.rx_fifo_empty && sp.rx_idle) begin
            rx_pd_nxt = 1'b1;
        end
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            tx_st_r <= UAP_TX_ON;
            rx_pd_r <= 1'b0;
            rxd_prev_r <= 1'b1;
            ring_prev_r <= 1'b0;
            ring_delta_r <= 1'b0;
        end else begin
            tx_st_r <= tx_st_nxt;
            rx_pd_r <= rx_pd_nxt;
            rxd_prev_r <= sp.rxd;
            ring_prev_r <= sp.ring_line;
            // Ring detect stays alive in every power state
            ring_delta_r <= ring_edge;
        end
    end

    assign sp.tx_pd = tx_st_r == UAP_TX_DOWN;
    assign sp.rx_pd = rx_pd_r;
    assign sp.ring_delta = ring_delta_r;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!nrst_in);

    a_tx_write_wakes: assert property (sp.tx_write |=> !sp.tx_pd)
        else $error("transmitter stayed down after buffer write");
    a_rx_edge_wakes: assert property (rxd_edge |=> !sp.rx_pd)
        else $error("receiver stayed down after line change");
    a_tx_entry_cond: assert property ($rose(sp.tx_pd) |->
        $past(sp.thr_empty && sp.tsr_empty && sp.auto_en))
        else $error("transmitter slept while busy");
    a_tx_idle_sleeps: assert property (sp.auto_en && sp.thr_empty &&
        sp.tsr_empty && !sp.tx_write ##1 sp.auto_en && !sp.tx_write
        |=> sp.tx_pd)
        else $error("idle transmitter did not sleep");
    a_rx_entry_cond: assert property ($rose(sp.rx_pd) |->
        $past(sp.rx_fifo_empty && sp.rx_idle && sp.auto_en))
        else $error("receiver slept while busy");
    a_ring_alive: assert property ($changed(sp.ring_line) |=>
        sp.ring_delta)
        else $error("ring change not reported");
    a_disable_wakes: assert property (!sp.auto_en |=>
        !sp.tx_pd && !sp.rx_pd)
        else $error("serial block asleep with auto power off");

    c_tx_sleep_wake: cover property (sp.tx_pd ##1 !sp.tx_pd);
    c_rx_sleep_wake: cover property (sp.rx_pd ##1 !sp.rx_pd);
    c_ring_while_down: cover property (sp.rx_pd && sp.ring_delta);

endmodule

//--- uap_port_power.sv
// Port power control top level with its Avalon-MM register slave
`timescale 1ns/10ps
//
// Function
// - Transmitter wakes as soon as the transmit holding buffer is written.
// - Receiver wakes whenever the serial receive input changes level.
// - One bit of configuration register one commands parallel port power.
// - Configuration register seven bit 4 allows idle EPP/ECP logic to sleep.
// - With auto power, EPP sleeps when configuration does not enable EPP.
// - With auto power in ECP mode, EPP sleeps unless ECR selects EPP.
// - With auto power, ECP sleeps when configuration does not enable ECP.
// - With auto power in ECP mode, ECP sleeps for SPP, PS/2 or EPP.
// - Parallel sleep states are re-evaluated when ECR or port mode changes.
// - Configuration register seven bits 5 and 6 enable each serial port.
// - Transmitter sleeps once holding buffer and shift register are empty.
// - Receiver sleeps only with empty FIFO and idle awaiting a start bit.
// - Ring indicator changes are still reported while a port sleeps.
module uap_port_power (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic nrst_in,
    // Avalon-MM slave
    input wire logic [uap_pkg::ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [uap_pkg::DATA_W-1:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [uap_pkg::DATA_W-1:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // Serial port status, one bit per port
    input wire logic [uap_pkg::NUM_SP-1:0] tx_holding_write_in,
    input wire logic [uap_pkg::NUM_SP-1:0] tx_holding_empty_in,
    input wire logic [uap_pkg::NUM_SP-1:0] tx_shift_empty_in,
    input wire logic [uap_pkg::NUM_SP-1:0] rx_fifo_empty_in,
    input wire logic [uap_pkg::NUM_SP-1:0] rx_idle_in,
    input wire logic [uap_pkg::NUM_SP-1:0] serial_receive_input_in,
    input wire logic [uap_pkg::NUM_SP-1:0] ring_indicator_input_in,
    // Serial power outputs
    output logic [uap_pkg::NUM_SP-1:0] tx_lowpwr_out,
    output logic [uap_pkg::NUM_SP-1:0] rx_lowpwr_out,
    output logic [uap_pkg::NUM_SP-1:0] ring_change_out,
    // Parallel power outputs
    output logic epp_lowpwr_out,
    output logic ecp_lowpwr_out,
    output logic pp_powerdown_out
);

    ////////////////////////////////////////////////////////////////////////
    // Register slave: one wait state on every access

    logic [7:0] cfg1_r;
    logic [7:0] cfg1_nxt;
    logic [7:0] cfg7_r;
    logic [7:0] cfg7_nxt;
    logic [1:0] pmode_r;
    logic [1:0] pmode_nxt;
    logic [7:0] ecr_r;
    logic [7:0] ecr_nxt;
    logic ack_r;
    logic ack_nxt;
    logic [uap_pkg::DATA_W-1:0] rdata_r;
    logic [uap_pkg::DATA_W-1:0] rdata_nxt;
    logic [7:0] status;
    logic req;
    logic wr_take;
    logic lane0;

    assign req = avs_read_in || avs_write_in;
    assign lane0 = avs_byteenable_in[0];
    assign wr_take = avs_write_in && ack_r && lane0;
    assign avs_waitrequest_out = req && !ack_r;
    assign avs_readdata_out = rdata_r;

    always_comb begin
        ack_nxt = req && !ack_r;
        cfg1_nxt = cfg1_r;
        cfg7_nxt = cfg7_r;
        pmode_nxt = pmode_r;
        ecr_nxt = ecr_r;
        rdata_nxt = rdata_r;
        if (wr_take) begin
            case (avs_address_in)
                uap_pkg::OFS_CFG1: cfg1_nxt = avs_writedata_in[7:0];
                uap_pkg::OFS_CFG7: cfg7_nxt = avs_writedata_in[7:0];
                uap_pkg::OFS_PMODE: pmode_nxt = avs_writedata_in[1:0];
                uap_pkg::OFS_ECR: ecr_nxt = avs_writedata_in[7:0];
                default: cfg1_nxt = cfg1_r;
            endcase
        end
        // Read data latched in the wait cycle, stands at the release edge
        if (avs_read_in && !ack_r) begin
            case (avs_address_in)
                uap_pkg::OFS_CFG1: rdata_nxt = {24'h000000, cfg1_r};
                uap_pkg::OFS_CFG7: rdata_nxt = {24'h000000, cfg7_r};
                uap_pkg::OFS_PMODE: rdata_nxt = {30'h00000000, pmode_r};
                uap_pkg::OFS_ECR: rdata_nxt = {24'h000000, ecr_r};
                uap_pkg::OFS_STAT: rdata_nxt = {24'h000000, status};
                default: rdata_nxt = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ack_r <= 1'b0;
            cfg1_r <= uap_pkg::CFG1_RST;
            cfg7_r <= uap_pkg::CFG7_RST;
            pmode_r <= uap_pkg::PMODE_RST;
            ecr_r <= uap_pkg::ECR_RST;
            rdata_r <= 32'h00000000;
        end else begin
            ack_r <= ack_nxt;
            cfg1_r <= cfg1_nxt;
            cfg7_r <= cfg7_nxt;
            pmode_r <= pmode_nxt;
            ecr_r <= ecr_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial ports

    genvar gi;
    generate
        for (gi = 0; gi < uap_pkg::NUM_SP; gi++) begin : g_sp
            uap_sp_if spi ();
            assign spi.auto_en = cfg7_r[uap_pkg::CFG7_SP_AUTO_LSB + gi];
            assign spi.tx_write = tx_holding_write_in[gi];
            assign spi.thr_empty = tx_holding_empty_in[gi];
            assign spi.tsr_empty = tx_shift_empty_in[gi];
            assign spi.rx_fifo_empty = rx_fifo_empty_in[gi];
            assign spi.rx_idle = rx_idle_in[gi];
            assign spi.rxd = serial_receive_input_in[gi];
            assign spi.ring_line = ring_indicator_input_in[gi];
            assign tx_lowpwr_out[gi] = spi.tx_pd;
            assign rx_lowpwr_out[gi] = spi.rx_pd;
            assign ring_change_out[gi] = spi.ring_delta;
            uap_serial_pm u_pm (
                .mclk_in(mclk_in),
                .nrst_in(nrst_in),
                .sp(spi)
            );
            assign status[2*gi] = spi.tx_pd;
            assign status[2*gi+1] = spi.rx_pd;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Parallel port

    logic pp_auto;
    logic [2:0] ecr_mode;
    logic in_ecp;
    logic epp_pd_r;
    logic epp_pd_nxt;
    logic ecp_pd_r;
    logic ecp_pd_nxt;
    logic ppd_r;
    logic ppd_nxt;

    assign pp_auto = cfg7_r[uap_pkg::CFG7_PP_AUTO_BIT];
    assign ecr_mode = ecr_r[uap_pkg::ECR_MODE_LSB +: 3];
    assign in_ecp = uap_pkg::uap_ecp_cfg(pmode_r);

    // Recomputed every cycle, so any mode or ECR change takes effect next
    always_comb begin
        epp_pd_nxt = 1'b0;
        ecp_pd_nxt = 1'b0;
        if (pp_auto) begin
            if (!uap_pkg::uap_epp_cfg(pmode_r)) begin
                epp_pd_nxt = 1'b1;
            end else if (in_ecp && ecr_mode != uap_pkg::ECR_EPP) begin
                epp_pd_nxt = 1'b1;
            end
            if (!in_ecp) begin
                ecp_pd_nxt = 1'b1;
            end else if (ecr_mode == uap_pkg::ECR_SPP ||
                         ecr_mode == uap_pkg::ECR_PS2 ||
                         ecr_mode == uap_pkg::ECR_EPP) begin
                ecp_pd_nxt = 1'b1;
            end
        end
        // Set bit means the port is powered
        ppd_nxt = !cfg1_r[uap_pkg::CFG1_PP_PWR_BIT];
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            epp_pd_r <= 1'b0;
            ecp_pd_r <= 1'b0;
            ppd_r <= 1'b0;
        end else begin
            epp_pd_r <= epp_pd_nxt;
            ecp_pd_r <= ecp_pd_nxt;
            ppd_r <= ppd_nxt;
        end
    end

    assign epp_lowpwr_out = epp_pd_r;
    assign ecp_lowpwr_out = ecp_pd_r;
    assign pp_powerdown_out = ppd_r;
    assign status[uap_pkg::STAT_EPP_BIT] = epp_pd_r;
    assign status[uap_pkg::STAT_ECP_BIT] = ecp_pd_r;
    assign status[uap_pkg::STAT_PPD_BIT] = ppd_r;
    assign status[7] = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!nrst_in);

    a_pp_direct: assert property (##1 pp_powerdown_out ==
        !$past(cfg1_r[uap_pkg::CFG1_PP_PWR_BIT]))
        else $error("parallel power does not follow its control bit");
    a_pp_auto_gate: assert property (!$past(pp_auto) |->
        !epp_lowpwr_out && !ecp_lowpwr_out)
        else $error("parallel block asleep without auto power");
    a_epp_not_cfg: assert property (pp_auto &&
        !uap_pkg::uap_epp_cfg(pmode_r) |=> epp_lowpwr_out)
        else $error("unconfigured EPP logic left awake");
    a_epp_ecr: assert property (pp_auto && in_ecp &&
        uap_pkg::uap_epp_cfg(pmode_r) |=>
        epp_lowpwr_out == ($past(ecr_mode) != uap_pkg::ECR_EPP))
        else $error("EPP power wrong for ECR mode");
    a_ecp_not_cfg: assert property (pp_auto && !in_ecp
        |=> ecp_lowpwr_out)
        else $error("unconfigured ECP logic left awake");
    a_ecp_ecr: assert property (pp_auto && in_ecp &&
        (ecr_mode == uap_pkg::ECR_FIFO || ecr_mode == uap_pkg::ECR_ECP)
        |=> !ecp_lowpwr_out)
        else $error("ECP logic asleep in its own mode");
    a_sp_enable: assert property (!cfg7_r[uap_pkg::CFG7_SP_AUTO_LSB]
        |=> !tx_lowpwr_out[0] && !rx_lowpwr_out[0])
        else $error("serial port one asleep while disabled");
    a_bus_wait: assert property (req && !ack_r |=>
        !avs_waitrequest_out)
        else $error("bus access not released after one wait state");

    c_ecr_to_epp: cover property (epp_lowpwr_out ##1 !epp_lowpwr_out);
    c_bus_write: cover property (wr_take);

endmodule

//--- uap_host_model.sv
// Host software model: an Avalon-MM master that reaches the registers
`timescale 1ns/10ps
module uap_host_model (
    // Clock
    input wire logic mclk_in,
    // Avalon-MM master side
    output logic [uap_pkg::ADDR_W-1:0] avs_address_out,
    output logic avs_read_out,
    output logic avs_write_out,
    output logic [uap_pkg::DATA_W-1:0] avs_writedata_out,
    output logic [3:0] avs_byteenable_out,
    input wire logic [uap_pkg::DATA_W-1:0] avs_readdata_in,
    input wire logic avs_waitrequest_in
);
    initial begin
        avs_address_out = '0;
        avs_read_out = 1'b0;
        avs_write_out = 1'b0;
        avs_writedata_out = '0;
        avs_byteenable_out = 4'h0;
    end

    // The request stands until waitrequest is seen low; the count bounds it
    task automatic xfer(input logic rd, input logic [4:0] a,
        input logic [31:0] d, input logic [3:0] be,
        output logic [31:0] q, output logic ok);
        logic w;
        int n;
        w = 1'b1;
        n = 0;
        q = '0;
        @(posedge mclk_in);
        avs_address_out <= a;
        avs_read_out <= rd;
        avs_write_out <= !rd;
        avs_writedata_out <= d;
        avs_byteenable_out <= be;
        // Values read right after the edge are those the edge sampled
        while (w && n < 20) begin
            @(posedge mclk_in);
            w = avs_waitrequest_in;
            q = avs_readdata_in;
            n++;
        end
        avs_read_out <= 1'b0;
        avs_write_out <= 1'b0;
        ok = (w === 1'b0);
    endtask
endmodule

//--- tb_uap_port_power.sv
// Self-checking bench for the port power control block
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
    error_cnt++; \
    $display("BAD %0t got %h expected %h", $time, (g), (e)); end end
module tb_uap_port_power;
    logic mclk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic [4:0] adr;
    logic rd_s, wr_s, wait_s;
    logic [31:0] wdat, rdat, q;
    logic [3:0] be;
    logic [1:0] tx_wr = 2'h0, tx_emp = 2'h3, sh_emp = 2'h3;
    logic [1:0] rx_emp = 2'h3, rx_idle = 2'h3, rxd = 2'h3, ring_ln = 2'h0;
    logic [1:0] tx_lp, rx_lp, ring;
    logic epp_lp, ecp_lp, pp_dn;
    int error_cnt = 0;
    int total_checks = 0;

    initial begin
        forever #10 mclk_in = ~mclk_in;
    end

    uap_host_model u_host (.mclk_in(mclk_in), .avs_address_out(adr),
        .avs_read_out(rd_s), .avs_write_out(wr_s),
        .avs_writedata_out(wdat), .avs_byteenable_out(be),
        .avs_readdata_in(rdat), .avs_waitrequest_in(wait_s));

    uap_port_power u_dut (.mclk_in(mclk_in), .nrst_in(nrst_in),
        .avs_address_in(adr), .avs_read_in(rd_s), .avs_write_in(wr_s),
        .avs_writedata_in(wdat), .avs_byteenable_in(be),
        .avs_readdata_out(rdat), .avs_waitrequest_out(wait_s),
        .tx_holding_write_in(tx_wr), .tx_holding_empty_in(tx_emp),
        .tx_shift_empty_in(sh_emp), .rx_fifo_empty_in(rx_emp),
        .rx_idle_in(rx_idle), .serial_receive_input_in(rxd),
        .ring_indicator_input_in(ring_ln), .tx_lowpwr_out(tx_lp),
        .rx_lowpwr_out(rx_lp), .ring_change_out(ring),
        .epp_lowpwr_out(epp_lp), .ecp_lowpwr_out(ecp_lp),
        .pp_powerdown_out(pp_dn));

    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic acc(input logic r, input logic [4:0] a,
        input logic [7:0] d, input logic [3:0] e);
        logic ok;
        u_host.xfer(r, a, {24'h0, d}, e, q, ok);
        if (!ok) begin
            error_cnt++;
            $display("BAD %0t bus access hung", $time);
            wrap_up();
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        acc(1'b0, a, d, 4'hf);
    endtask

    // Fixed waits below follow the registered one-edge output latency
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_in);
        @(negedge mclk_in);
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic t_reset_vals();
        acc(1'b1, uap_pkg::OFS_CFG1, 8'h0, 4'hf);
        `CHK(q, 32'h9c)
        acc(1'b1, uap_pkg::OFS_CFG7, 8'h0, 4'hf);
        `CHK(q, 32'h0)
        wr(uap_pkg::OFS_STAT, 8'hff);
        acc(1'b1, uap_pkg::OFS_STAT, 8'h0, 4'hf);
        `CHK(q, 32'h0)
        acc(1'b0, uap_pkg::OFS_CFG7, 8'h70, 4'he);
        wr(5'h14, 8'hff);
        acc(1'b1, 5'h14, 8'h0, 4'hf);
        `CHK(q, 32'h0)
        cyc(2);
        `CHK({tx_lp, rx_lp, epp_lp, ecp_lp}, 6'h0)
    endtask

    task automatic t_tx();
        wr(uap_pkg::OFS_CFG7, 8'h20);
        cyc(2);
        `CHK(tx_lp, 2'b01)
        `CHK(rx_lp, 2'b01)
        acc(1'b1, uap_pkg::OFS_STAT, 8'h0, 4'hf);
        `CHK(q, 32'h03)
        // Holding buffer filled by the write keeps the transmitter awake
        @(posedge mclk_in);
        tx_wr <= 2'b01;
        tx_emp <= 2'b10;
        @(posedge mclk_in);
        tx_wr <= 2'b00;
        @(negedge mclk_in);
        `CHK(tx_lp, 2'b00)
        cyc(3);
        `CHK(tx_lp, 2'b00)
        @(posedge mclk_in);
        tx_emp <= 2'b11;
        cyc(2);
        `CHK(tx_lp, 2'b01)
    endtask

    task automatic t_rx();
        @(posedge mclk_in);
        rxd <= 2'b10;
        @(posedge mclk_in);
        @(negedge mclk_in);
        `CHK(rx_lp, 2'b00)
        cyc(1);
        `CHK(rx_lp, 2'b01)
        @(posedge mclk_in);
        rx_idle <= 2'b10;
        rxd <= 2'b11;
        cyc(3);
        `CHK(rx_lp, 2'b00)
        @(posedge mclk_in);
        rx_idle <= 2'b11;
        cyc(2);
        `CHK(rx_lp, 2'b01)
    endtask

    task automatic t_ring();
        for (int i = 0; i < 2; i++) begin
            @(posedge mclk_in);
            ring_ln <= ~ring_ln;
            @(posedge mclk_in);
            @(negedge mclk_in);
            `CHK(ring, 2'b11)
            `CHK(rx_lp, 2'b01)
            @(negedge mclk_in);
            `CHK(ring, 2'b00)
        end
    endtask

    task automatic t_auto_sel();
        wr(uap_pkg::OFS_CFG7, 8'h40);
        cyc(2);
        `CHK(tx_lp, 2'b10)
        `CHK(rx_lp, 2'b10)
        wr(uap_pkg::OFS_CFG7, 8'h00);
        cyc(2);
        `CHK({tx_lp, rx_lp}, 4'h0)
    endtask

    task automatic t_parallel();
        logic ee, ce, pe, pc;
        for (int au = 0; au < 2; au++) begin
            wr(uap_pkg::OFS_CFG7, au[0] ? 8'h10 : 8'h00);
            for (int pm = 0; pm < 4; pm++) begin
                wr(uap_pkg::OFS_PMODE, pm[7:0]);
                for (int m = 0; m < 8; m++) begin
                    wr(uap_pkg::OFS_ECR, {m[2:0], 5'h0});
                    cyc(2);
                    pe = (pm == 1) || (pm == 3);
                    pc = (pm == 2) || (pm == 3);
                    ee = au[0] && (!pe || (pc && m != 4));
                    ce = au[0] && (!pc || m == 0 || m == 1 || m == 4);
                    `CHK(epp_lp, ee)
                    `CHK(ecp_lp, ce)
                end
            end
        end
    endtask

    task automatic t_ppower();
        wr(uap_pkg::OFS_CFG1, 8'h98);
        cyc(2);
        `CHK(pp_dn, 1'b1)
        // Last parallel setting left EPP asleep and ECP awake
        acc(1'b1, uap_pkg::OFS_STAT, 8'h0, 4'hf);
        `CHK(q, 32'h50)
        wr(uap_pkg::OFS_CFG1, 8'h9c);
        cyc(2);
        `CHK(pp_dn, 1'b0)
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge mclk_in);
        nrst_in <= 1'b1;
        @(posedge mclk_in);
        t_reset_vals();
        t_tx();
        t_rx();
        t_ring();
        t_auto_sel();
        t_parallel();
        t_ppower();
        wrap_up();
    end
endmodule
